// File: verilog/ocd_defines.svh
// register offsets, field positions, reset values and timing counts of the clock control block
`ifndef OCD_DEFINES_SVH
`define OCD_DEFINES_SVH
`define OCD_OFF_OSC_CTRL 4'h0
`define OCD_OFF_CLK_DIV 4'h4
`define OCD_OFF_PLL_FBD 4'h8
`define OCD_OFF_FRC_TUN 4'hC
`define OCD_OFF_UNLOCK 5'h10
`define OCD_UNLOCK_KEY1 16'h5A5A
`define OCD_UNLOCK_KEY2 16'hA5A5
`define OCD_CUR_LSB 12
`define OCD_REQ_LSB 8
`define OCD_FREEZE_BIT 7
`define OCD_LOCK_BIT 5
`define OCD_FAIL_BIT 3
`define OCD_SOSC_BIT 1
`define OCD_SWREQ_BIT 0
`define OCD_ROI_BIT 15
`define OCD_DOZE_LSB 12
`define OCD_REDUCE_RATIO_ENABLE_BIT 11
`define OCD_FAST_RC_POSTDIV_LSB 8
`define OCD_POST_LSB 6
`define OCD_PRE_LSB 0
`define OCD_DOZE_RST 3'h3
`define OCD_FAST_RC_POSTDIV_RST 3'h0
`define OCD_POST_RST 2'h1
`define OCD_PRE_RST 5'h00
`define OCD_MULT_RST 9'h030
`define OCD_TRIM_RST 6'h00
`define OCD_SETTLE_CYC 4'hA
`endif

// File: verilog/ocd_pkg.sv
// types of the clock control block
package ocd_pkg;
   typedef enum logic [2:0] {
      OCD_SRC_FRC, OCD_SRC_FRC_PLL, OCD_SRC_PRI, OCD_SRC_PRI_PLL,
      OCD_SRC_SEC, OCD_SRC_LOW_POWER_RC_OSC, OCD_SRC_FRC16, OCD_SRC_FRCN
   } ocd_src_t;
   typedef enum {OCD_IDLE, OCD_START, OCD_WAIT_RDY, OCD_SETTLE, OCD_CHANGE} ocd_state_t;
   typedef struct packed {
      logic [2:0] doze_ratio;
      logic doze_active;
      logic [2:0] fast_rc_postdiv;
      logic [1:0] pll_out_div;
      logic [4:0] pll_in_prediv;
      logic [8:0] pll_feedback_mult;
      logic [5:0] fast_rc_trim_code;
      logic secondary_osc_enable;
   } ocd_clk_cfg_t;
endpackage : ocd_pkg

// File: verilog/ocd_clock_ctrl.sv
// oscillator select, switch sequencing and divider registers behind an axi4-lite slave
`timescale 1ns/10ps
`include "ocd_defines.svh"
module ocd_clock_ctrl import ocd_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] cfg_initial_source,
   input wire logic switch_monitor_cfg_bit0,
   input wire logic switching_enabled,
   input wire logic fail_detect,
   input wire logic irq_event,
   input wire logic pll_locked,
   input wire logic new_src_ready,
   input wire logic new_clk_edge,
   input wire logic mux_aligned,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output ocd_src_t active_source,
   output logic source_enable_req,
   output logic [2:0] target_source,
   output ocd_clk_cfg_t clk_cfg
);
   logic [4:0] aw_addr;
   logic aw_full;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_full;
   logic wr_go;
   logic [2:0] current_source_sel;
   logic [2:0] requested_source_sel;
   logic clock_cfg_freeze;
   logic clock_fail_flag;
   logic pll_lock_flag;
   logic secondary_osc_enable;
   logic switch_request;
   logic recover_on_irq;
   logic [2:0] doze_ratio;
   logic reduce_ratio_enable;
   logic [2:0] fast_rc_postdiv;
   logic [1:0] pll_out_div;
   logic [4:0] pll_in_prediv;
   logic [8:0] pll_feedback_mult;
   logic [5:0] fast_rc_trim_code;
   logic [1:0] unlock_stage;
   logic cfg_captured;
   logic frozen;
   logic ctrl_wr;
   logic div_wr;
   logic start_switch;
   logic switch_done;
   logic [3:0] settle_cnt;
   ocd_state_t state;
   logic [15:0] osc_ctrl_view;
   logic [15:0] rd_word;

   assign frozen = clock_cfg_freeze & switch_monitor_cfg_bit0;

   // write address and data are latched independently, so either may arrive first
   assign s_axi_awready = !aw_full;
   assign s_axi_wready = !w_full;
   assign wr_go = aw_full && w_full && !s_axi_bvalid;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_full <= 1'b0;
         aw_addr <= 5'h00;
      end else if (s_axi_awvalid && !aw_full) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_full <= 1'b0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && !w_full) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
         w_full <= 1'b0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // ignored writes still answer okay; software sees them only by reading back
   assign s_axi_bresp = 2'h0;

   // unlock: key1 then key2 written to the unlock word arms one control write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         unlock_stage <= 2'h0;
      end else if (wr_go) begin
         if (aw_addr == `OCD_OFF_UNLOCK && w_data[15:0] == `OCD_UNLOCK_KEY1) begin
            unlock_stage <= 2'h1;
         end else if (aw_addr == `OCD_OFF_UNLOCK && w_data[15:0] == `OCD_UNLOCK_KEY2 && unlock_stage == 2'h1) begin
            unlock_stage <= 2'h2;
         end else begin
            unlock_stage <= 2'h0;
         end
      end
   end
   assign ctrl_wr = wr_go && aw_addr == {1'b0, `OCD_OFF_OSC_CTRL} && unlock_stage == 2'h2;
   assign div_wr = wr_go && !frozen;

   // only the power-on reset reaches these; other resets are not ports of this block
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_captured <= 1'b0;
         requested_source_sel <= 3'h0;
         clock_cfg_freeze <= 1'b0;
         secondary_osc_enable <= 1'b0;
      end else if (!cfg_captured) begin
         cfg_captured <= 1'b1;
         requested_source_sel <= cfg_initial_source;
      end else if (ctrl_wr) begin
         if (w_strb[1] && !frozen) begin
            requested_source_sel <= w_data[`OCD_REQ_LSB +: 3];
         end
         if (w_strb[0]) begin
            clock_cfg_freeze <= clock_cfg_freeze | w_data[`OCD_FREEZE_BIT];
            secondary_osc_enable <= w_data[`OCD_SOSC_BIT];
         end
      end
   end

   // switch request: software sets, hardware clears; held low when switching is disabled
   assign start_switch = state == OCD_IDLE && switch_request;
   assign switch_done = state == OCD_CHANGE && mux_aligned;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         switch_request <= 1'b0;
      end else if (!switching_enabled) begin
         switch_request <= 1'b0;
      end else if (ctrl_wr && w_strb[0] && w_data[`OCD_SWREQ_BIT] && !frozen) begin
         switch_request <= 1'b1;
      end else if (start_switch && requested_source_sel == current_source_sel) begin
         switch_request <= 1'b0;
      end else if (switch_done) begin
         switch_request <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= OCD_IDLE;
         settle_cnt <= 4'h0;
      end else begin
         case (state)
            OCD_IDLE: begin
               if (start_switch && requested_source_sel != current_source_sel) begin
                  state <= OCD_START;
               end
            end
            OCD_START: state <= OCD_WAIT_RDY;
            OCD_WAIT_RDY: begin
               if (new_src_ready && (pll_locked || !(target_source == OCD_SRC_FRC_PLL ||
                   target_source == OCD_SRC_PRI_PLL))) begin
                  state <= OCD_SETTLE;
                  settle_cnt <= 4'h0;
               end
            end
            OCD_SETTLE: begin
               if (new_clk_edge) begin
                  settle_cnt <= settle_cnt + 4'h1;
                  if (settle_cnt == `OCD_SETTLE_CYC - 4'h1) begin
                     state <= OCD_CHANGE;
                  end
               end
            end
            OCD_CHANGE: begin
               if (mux_aligned) begin
                  state <= OCD_IDLE;
               end
            end
            default: state <= OCD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         current_source_sel <= 3'h0;
      end else if (!cfg_captured) begin
         current_source_sel <= cfg_initial_source;
      end else if (switch_done) begin
         current_source_sel <= requested_source_sel;
      end
   end
   assign target_source = requested_source_sel;
   assign source_enable_req = state == OCD_WAIT_RDY || state == OCD_SETTLE || state == OCD_CHANGE;
   assign active_source = ocd_src_t'(current_source_sel);

   // fail event wins over a software clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clock_fail_flag <= 1'b0;
      end else if (fail_detect) begin
         clock_fail_flag <= 1'b1;
      end else if (state == OCD_START) begin
         clock_fail_flag <= 1'b0;
      end else if (ctrl_wr && w_strb[0] && !w_data[`OCD_FAIL_BIT]) begin
         clock_fail_flag <= 1'b0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pll_lock_flag <= 1'b0;
      end else if (state == OCD_START) begin
         pll_lock_flag <= 1'b0;
      end else begin
         pll_lock_flag <= pll_locked;
      end
   end

   // divider, feedback and trim registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         recover_on_irq <= 1'b0;
         doze_ratio <= `OCD_DOZE_RST;
         fast_rc_postdiv <= `OCD_FAST_RC_POSTDIV_RST;
         pll_out_div <= `OCD_POST_RST;
         pll_in_prediv <= `OCD_PRE_RST;
         pll_feedback_mult <= `OCD_MULT_RST;
         fast_rc_trim_code <= `OCD_TRIM_RST;
      end else if (div_wr) begin
         if (aw_addr == {1'b0, `OCD_OFF_CLK_DIV}) begin
            if (w_strb[1]) begin
               recover_on_irq <= w_data[`OCD_ROI_BIT];
               doze_ratio <= w_data[`OCD_DOZE_LSB +: 3];
               fast_rc_postdiv <= w_data[`OCD_FAST_RC_POSTDIV_LSB +: 3];
            end
            if (w_strb[0]) begin
               pll_out_div <= w_data[`OCD_POST_LSB +: 2];
               pll_in_prediv <= w_data[`OCD_PRE_LSB +: 5];
            end
         end
         if (aw_addr == {1'b0, `OCD_OFF_PLL_FBD}) begin
            if (w_strb[1]) begin
               pll_feedback_mult[8] <= w_data[8];
            end
            if (w_strb[0]) begin
               pll_feedback_mult[7:0] <= w_data[7:0];
            end
         end
         if (aw_addr == {1'b0, `OCD_OFF_FRC_TUN} && w_strb[0]) begin
            fast_rc_trim_code <= w_data[5:0];
         end
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reduce_ratio_enable <= 1'b0;
      end else if (irq_event && recover_on_irq) begin
         reduce_ratio_enable <= 1'b0;
      end else if (div_wr && aw_addr == {1'b0, `OCD_OFF_CLK_DIV} && w_strb[1]) begin
         reduce_ratio_enable <= w_data[`OCD_REDUCE_RATIO_ENABLE_BIT];
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_cfg <= '0;
      end else begin
         clk_cfg.doze_ratio <= reduce_ratio_enable ? doze_ratio : 3'h0;
         clk_cfg.doze_active <= reduce_ratio_enable;
         clk_cfg.fast_rc_postdiv <= fast_rc_postdiv;
         clk_cfg.pll_out_div <= pll_out_div;
         clk_cfg.pll_in_prediv <= pll_in_prediv;
         clk_cfg.pll_feedback_mult <= pll_feedback_mult;
         clk_cfg.fast_rc_trim_code <= fast_rc_trim_code;
         clk_cfg.secondary_osc_enable <= secondary_osc_enable;
      end
   end

   // read side; unimplemented bits are zero
   assign osc_ctrl_view = {1'b0, current_source_sel, 1'b0, requested_source_sel, clock_cfg_freeze, 1'b0,
                           pll_lock_flag, 1'b0, clock_fail_flag, 1'b0, secondary_osc_enable, switch_request};
   always_comb begin
      case (s_axi_araddr)
         {1'b0, `OCD_OFF_OSC_CTRL}: rd_word = osc_ctrl_view;
         {1'b0, `OCD_OFF_CLK_DIV}: rd_word = {recover_on_irq, doze_ratio, reduce_ratio_enable, fast_rc_postdiv,
                                              pll_out_div, 1'b0, pll_in_prediv};
         {1'b0, `OCD_OFF_PLL_FBD}: rd_word = {7'h00, pll_feedback_mult};
         {1'b0, `OCD_OFF_FRC_TUN}: rd_word = {10'h000, fast_rc_trim_code};
         default: rd_word = 16'h0000;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > `OCD_OFF_UNLOCK) ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   switch_clears_a: assert property (@(posedge clock) disable iff (rst)
      switch_done |=> !switch_request && current_source_sel == $past(requested_source_sel))
      else $error("switch completion did not update source");
   fail_set_a: assert property (@(posedge clock) disable iff (rst)
      fail_detect |=> clock_fail_flag) else $error("fail flag not set");
   locked_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_go && aw_addr == 5'h00 && unlock_stage != 2'h2 && cfg_captured |=> $stable(requested_source_sel))
      else $error("control write accepted without unlock");
   roi_clear_a: assert property (@(posedge clock) disable iff (rst)
      irq_event && recover_on_irq |=> !reduce_ratio_enable) else $error("ratio not recovered");
   redundant_abort_a: assert property (@(posedge clock) disable iff (rst)
      start_switch && requested_source_sel == current_source_sel && switching_enabled |=> !switch_request)
      else $error("redundant switch not aborted");
   start_clears_a: assert property (@(posedge clock) disable iff (rst)
      state == OCD_START && !fail_detect |=> !clock_fail_flag && !pll_lock_flag)
      else $error("flags not cleared at switch start");
   settle_wait_a: assert property (@(posedge clock) disable iff (rst)
      $rose(state == OCD_SETTLE) |-> state != OCD_CHANGE [*8] ##1 state != OCD_CHANGE [*2])
      else $error("settle too short");
   ratio_forced_a: assert property (@(posedge clock) disable iff (rst)
      !reduce_ratio_enable |=> clk_cfg.doze_ratio == 3'h0) else $error("ratio not 1:1");
   frozen_div_a: assert property (@(posedge clock) disable iff (rst)
      frozen && !irq_event |=> $stable(pll_feedback_mult) && $stable(pll_in_prediv))
      else $error("frozen configuration changed");
endmodule : ocd_clock_ctrl

// File: verif/ocd_osc_model.sv
// behavioural oscillator sources and pll behind the clock control block
`timescale 1ns/10ps
module ocd_osc_model import ocd_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire logic source_enable_req,
   input wire logic [2:0] target_source,
   input wire logic slow,
   output logic pll_locked,
   output logic new_src_ready,
   output logic new_clk_edge,
   output logic mux_aligned
);
   logic [4:0] start_cnt;
   logic [1:0] phase;
   logic lock_hold;
   logic uses_pll;
   assign uses_pll = (target_source == 3'h1) || (target_source == 3'h3);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         start_cnt <= 5'h00;
         phase <= 2'h0;
         lock_hold <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         if (!source_enable_req) begin
            start_cnt <= 5'h00;
         end else if (start_cnt != 5'h1F) begin
            start_cnt <= start_cnt + 5'h01;
         end
         if (source_enable_req) begin
            lock_hold <= uses_pll && (start_cnt >= (slow ? 5'h0E : 5'h04));
         end
      end
   end
   // a slow source takes longer to start and lock; the pll stays locked after the switch
   assign new_src_ready = source_enable_req && (start_cnt >= (slow ? 5'h0C : 5'h03));
   assign pll_locked = uses_pll && (source_enable_req ? (start_cnt >= (slow ? 5'h0E : 5'h04)) : lock_hold);
   assign new_clk_edge = source_enable_req && (!slow || (phase == 2'h0));
   // the mux reports alignment on every other cycle, so it may come at once or one cycle later
   assign mux_aligned = source_enable_req && phase[0];
endmodule : ocd_osc_model

// File: verif/ocd_clock_ctrl_tb_top.sv
// register-level testbench of the clock control block with an oscillator model
`timescale 1ns/10ps
`include "ocd_defines.svh"
module ocd_clock_ctrl_tb_top import ocd_pkg::*; ;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic mon_bit0 = 1'b0;
   logic fail_detect = 1'b0;
   logic irq_event = 1'b0;
   logic slow = 1'b0;
   logic pll_locked, new_src_ready, new_clk_edge, mux_aligned;
   logic [4:0] awaddr = 5'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [4:0] araddr = 5'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, source_enable_req;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, rd;
   logic [2:0] target_source;
   ocd_src_t active_source;
   ocd_clk_cfg_t clk_cfg;
   int n_fail = 0;
   int n_checks = 0;
   int edge_cnt = 0;
   always #2 clock = ~clock;
   // counts new-clock edges seen once the new source is usable
   always @(posedge clock) begin
      if (source_enable_req && new_clk_edge && new_src_ready && (pll_locked || !target_source[0])) edge_cnt++;
   end
   ocd_clock_ctrl uut (.clock(clock), .rst(rst), .cfg_initial_source(3'h2), .switch_monitor_cfg_bit0(mon_bit0),
      .switching_enabled(1'b1), .fail_detect(fail_detect), .irq_event(irq_event), .pll_locked(pll_locked),
      .new_src_ready(new_src_ready), .new_clk_edge(new_clk_edge), .mux_aligned(mux_aligned),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .active_source(active_source), .source_enable_req(source_enable_req),
      .target_source(target_source), .clk_cfg(clk_cfg));
   ocd_osc_model osc (.clock(clock), .rst(rst), .source_enable_req(source_enable_req),
      .target_source(target_source), .slow(slow), .pll_locked(pll_locked), .new_src_ready(new_src_ready),
      .new_clk_edge(new_clk_edge), .mux_aligned(mux_aligned));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 200) begin
         n_fail++;
         stop_test();
      end
      @(posedge clock);
   endtask : bus_write
   task automatic bus_read(input logic [4:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      if (n == 200) begin
         n_fail++;
         stop_test();
      end
      @(posedge clock);
   endtask : bus_read
   task automatic check_reg(input string what, input logic [4:0] a, input logic [31:0] exp);
      bus_read(a);
      check(what, rd, exp);
   endtask : check_reg
   // each ctrl_write call precedes its control register write with its own unlock pair
   task automatic ctrl_write(input logic [31:0] d);
      bus_write(`OCD_OFF_UNLOCK, {16'h0000, `OCD_UNLOCK_KEY1});
      bus_write(`OCD_OFF_UNLOCK, {16'h0000, `OCD_UNLOCK_KEY2});
      edge_cnt = 0;
      bus_write({1'b0, `OCD_OFF_OSC_CTRL}, d);
   endtask : ctrl_write
   task automatic wait_src(input ocd_src_t s);
      int n;
      for (n = 0; n < 500 && active_source !== s; n++) @(posedge clock);
      if (n == 500) begin
         n_fail++;
         stop_test();
      end
      repeat (2) @(posedge clock);
   endtask : wait_src
   task automatic pulse(input bit which_irq);
      if (which_irq) irq_event <= 1'b1;
      else fail_detect <= 1'b1;
      @(posedge clock);
      irq_event <= 1'b0;
      fail_detect <= 1'b0;
      @(posedge clock);
   endtask : pulse
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      check_reg("ctrl reset", 5'h00, 32'h2200);
      check_reg("div reset", 5'h04, 32'h3040);
      check_reg("fbd reset", 5'h08, 32'h0030);
      check_reg("tun reset", 5'h0C, 32'h0000);
      check("cfg reset", {2'h0, clk_cfg}, {5'h00, 1'b0, 3'h0, 2'h1, 5'h00, 9'h030, 6'h00, 1'b0});
      bus_write(5'h00, 32'h0102);
      check_reg("ctrl no unlock", 5'h00, 32'h2200);
      ctrl_write(32'h0202);
      check_reg("ctrl sosc", 5'h00, 32'h2202);
      check("sosc out", {31'h0, clk_cfg.secondary_osc_enable}, 32'h1);
      bus_write(5'h00, 32'h0000);
      check_reg("ctrl stale unlock", 5'h00, 32'h2202);
      ctrl_write(32'h0003);
      check_reg("ctrl pending", 5'h00, 32'h2003);
      wait_src(OCD_SRC_FRC);
      check_reg("ctrl to frc", 5'h00, 32'h0002);
      check("settle edges", {31'h0, edge_cnt >= 10}, 32'h1);
      ctrl_write(32'h0003);
      check_reg("ctrl redundant", 5'h00, 32'h0002);
      pulse(1'b0);
      check_reg("ctrl fail set", 5'h00, 32'h000A);
      slow <= 1'b1;
      ctrl_write(32'h0103);
      check_reg("ctrl flags cleared", 5'h00, 32'h0103);
      wait_src(OCD_SRC_FRC_PLL);
      check_reg("ctrl pll locked", 5'h00, 32'h1122);
      check("pll settle edges", {31'h0, edge_cnt >= 10}, 32'h1);
      pulse(1'b0);
      ctrl_write(32'h010A);
      check_reg("fail write one", 5'h00, 32'h112A);
      ctrl_write(32'h0102);
      check_reg("fail cleared", 5'h00, 32'h1122);
      // leave the pll source through plain fast rc only
      ctrl_write(32'h0003);
      wait_src(OCD_SRC_FRC);
      check_reg("ctrl lock drops", 5'h00, 32'h0002);
      bus_write(5'h04, 32'hFFFF_FFFF);
      check_reg("div all ones", 5'h04, 32'hFFDF);
      check("cfg all ones", {2'h0, clk_cfg}, {5'h07, 1'b1, 3'h7, 2'h3, 5'h1F, 9'h030, 6'h00, 1'b1});
      pulse(1'b1);
      check_reg("div irq roi", 5'h04, 32'hF7DF);
      check("doze forced", {29'h0, clk_cfg.doze_ratio}, 32'h0);
      bus_write(5'h04, 32'h3840);
      pulse(1'b1);
      check_reg("div irq no roi", 5'h04, 32'h3840);
      check("doze ratio", {29'h0, clk_cfg.doze_ratio}, 32'h3);
      bus_write(5'h08, 32'hFFFF_FFFF);
      check_reg("fbd all ones", 5'h08, 32'h01FF);
      bus_write(5'h0C, 32'hFFFF_FFFF);
      check_reg("tun all ones", 5'h0C, 32'h003F);
      check("trim out", {26'h0, clk_cfg.fast_rc_trim_code}, 32'h3F);
      bus_read(5'h14);
      check("unmapped resp", {30'h0, rr}, 32'h2);
      check("unmapped data", rd, 32'h0);
      bus_read(5'h02);
      check("unaligned resp", {30'h0, rr}, 32'h2);
      check("unaligned data", rd, 32'h0);
      // freeze is sticky, so it comes last
      mon_bit0 <= 1'b1;
      ctrl_write(32'h0082);
      check_reg("ctrl freeze", 5'h00, 32'h0082);
      ctrl_write(32'h0182);
      check_reg("ctrl frozen", 5'h00, 32'h0082);
      bus_write(5'h08, 32'h0010);
      check_reg("fbd frozen", 5'h08, 32'h01FF);
      // freeze bit alone does not block once the monitor option is off
      mon_bit0 <= 1'b0;
      bus_write(5'h08, 32'h0010);
      check_reg("fbd unfrozen", 5'h08, 32'h0010);
      stop_test();
   end
endmodule : ocd_clock_ctrl_tb_top
